// ---- rtl/ept_pkg.sv ----
/*
  Shared constants and types for the 8-bit interval / PWM / carrier timer.
  Assumes one system clock and a count-clock pulse generated outside.
*/
`default_nettype none

package ept_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int EPT_CNT_W  = 8;            // Counter and compare width
  localparam int EPT_ADDR_W = 16;           // Register address width
  localparam int EPT_DATA_W = 8;            // Register data width

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [EPT_ADDR_W-1:0] EPT_PORT1_DIRECTION_ADDR = 16'hff21;
  localparam logic [EPT_DATA_W-1:0] EPT_PORT1_DIRECTION_RST  = 8'hff; // All pins input
  localparam logic [EPT_ADDR_W-1:0] EPT_CARRIER_STATUS_ADDR  = 16'hff6d;
  localparam int EPT_CARRIER_FLAG_BIT = 0;  // Active gate flag, read only
  localparam int EPT_CARRIER_BUF_BIT  = 1;  // Buffered gate bit mirror
  localparam int EPT_TIMER0_PIN_BIT   = 5;  // Direction bit of timer 0 pin
  localparam int EPT_TIMER1_PIN_BIT   = 6;  // Direction bit of timer 1 pin

  // ==========================================================
  // Counter constants
  // ==========================================================
  localparam logic [EPT_CNT_W-1:0] EPT_CNT_ZERO = 8'h00;  // Counter clear value
  localparam logic [EPT_CNT_W-1:0] EPT_CNT_ONE  = 8'h01;  // Count step
  localparam logic [1:0] EPT_DUTY_SETTLE = 2'h3;          // Count clocks before transfer
  localparam logic [1:0] EPT_AGE_ZERO    = 2'h0;
  localparam logic [1:0] EPT_AGE_ONE     = 2'h1;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    EPT_MODE_INTERVAL = 2'b00,
    EPT_MODE_CARRIER  = 2'b01,
    EPT_MODE_PWM      = 2'b10,
    EPT_MODE_BAD      = 2'b11
  } ept_mode_t;

  typedef enum logic {
    EPT_PH_FIRST  = 1'b0,                   // Comparing first register
    EPT_PH_SECOND = 1'b1                    // Comparing second register
  } ept_phase_t;

endpackage : ept_pkg

`default_nettype wire

// ---- rtl/ept_carrier_gate.sv ----
/*
  Carrier gate transfer: brings the companion counter interrupt onto the
  count clock and moves the buffered gate bit into the active gate flag.
  Assumes count_tick_in is a one-cycle pulse per count clock.
*/
`default_nettype none

module ept_carrier_gate (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  // Count clock and companion event
  input  wire logic count_tick_in,
  input  wire logic companion_irq_in,
  input  wire logic carrier_gate_buffer_in,
  // Results
  output logic      synced_companion_interrupt_out,
  output logic      carrier_gate_flag_out
);
  import ept_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  logic sync_first;       // First stage, read only by second
  logic sync_prev;        // Previous synced level, for edge
  logic armed;            // Edge seen, transfer on next tick
  logic next_sync_first;
  logic next_synced;
  logic next_sync_prev;
  logic next_armed;
  logic next_flag;

  // Next values; everything advances only on count clocks
  always_comb begin
    next_sync_first = sync_first;
    next_synced     = synced_companion_interrupt_out;
    next_sync_prev  = sync_prev;
    next_armed      = armed;
    next_flag       = carrier_gate_flag_out;
    if (count_tick_in) begin
      next_sync_first = companion_irq_in;
      next_synced     = sync_first;
      next_sync_prev  = synced_companion_interrupt_out;
      // First clock after the synced rise arms, second copies
      next_armed      = synced_companion_interrupt_out && !sync_prev;
      if (armed) begin
        next_flag = carrier_gate_buffer_in;               // see R22
      end
    end
  end

  // Registers, synchronous reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync_first                     <= 1'b0;
      synced_companion_interrupt_out <= 1'b0;
      sync_prev                      <= 1'b0;
      armed                          <= 1'b0;
      carrier_gate_flag_out          <= 1'b0;
    end else begin
      sync_first                     <= next_sync_first;
      synced_companion_interrupt_out <= next_synced;
      sync_prev                      <= next_sync_prev;
      armed                          <= next_armed;
      carrier_gate_flag_out          <= next_flag;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_synced_rise;
    count_tick_in && synced_companion_interrupt_out && !sync_prev;
  endsequence

  AST_GATE_TRANSFER: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R22
    s_synced_rise ##1 (armed && count_tick_in) |=>
      carrier_gate_flag_out == $past(carrier_gate_buffer_in))
    else $error("gate flag not copied on second count clock");

endmodule : ept_carrier_gate

`default_nettype wire

// ---- rtl/ept_timer.sv ----
/*
  8-bit timer with two compare registers: interval/square wave, PWM and
  carrier generator modes, plus the port 1 direction register.
  Assumes a one-cycle count_tick_in per count clock, mode and compare
  values from a register file outside the timer, and a byte register port.
*/
`default_nettype none

// Contract
// R1: Reset loads port 1 direction with all ones
// R2: Direction bit zero drives, one floats pin
// R3: Software clears direction and latch for timer pins
// R4: Interval match raises interrupt, clears counter
// R5: Interval mode ignores the second compare
// R6: Output enabled interval match toggles output
// R7: Counting starts within one count clock
// R8: Stopping forces interrupt and output inactive
// R9: Period compare not rewritten during PWM
// R10: Period match clears, interrupts, activates, switches
// R11: Duty match deactivates, switches, no clear
// R12: Period N+1 clocks, active width M+1
// R13: Software keeps duty below period
// R14: Duty write latched, applied after three clocks
// R15: Software rewrites duty after each restart
// R16: Start masks one count clock, output idle
// R17: Carrier low width first, high second
// R18: High width rewritable, low width fixed
// R19: Companion counter gates carrier onto pin
// R20: Disabled counter held at zero
// R21: Idle level bit sets default output
// R22: Gate buffer copied second clock after edge
// R23: Interrupt one count clock wide, enabled only
module ept_timer #(
  parameter int HAS_CARRIER = 1             // Carrier mode exists on this instance
) (
  // Clock and reset
  input  wire logic                           core_clk_in,
  input  wire logic                           reset_in,
  // Register port
  input  wire logic [ept_pkg::EPT_ADDR_W-1:0] reg_addr_in,
  input  wire logic                           reg_wr_in,
  input  wire logic                           reg_rd_in,
  input  wire logic [ept_pkg::EPT_DATA_W-1:0] reg_wdata_in,
  output logic      [ept_pkg::EPT_DATA_W-1:0] reg_rdata_out,
  // Timer control
  input  wire logic                           count_tick_in,
  input  wire logic                           count_enable_bit_in,
  input  wire ept_pkg::ept_mode_t             timer_mode_in,
  input  wire logic                           output_enable_bit_in,
  input  wire logic                           idle_level_bit_in,
  input  wire logic [ept_pkg::EPT_CNT_W-1:0]  period_compare_in,
  input  wire logic [ept_pkg::EPT_CNT_W-1:0]  duty_compare_in,
  input  wire logic                           duty_compare_wr_in,
  // Carrier gating
  input  wire logic                           carrier_gate_buffer_in,
  input  wire logic                           companion_irq_in,
  // Outputs
  output logic                                match_interrupt_out,
  output logic                                timer_output_pin_out,
  output logic                                carrier_gate_flag_out,
  output logic                                synced_companion_interrupt_out,
  output logic      [ept_pkg::EPT_DATA_W-1:0] port1_direction_out
);
  import ept_pkg::*;

  // Refuse values the logic cannot serve
  if (HAS_CARRIER < 0 || HAS_CARRIER > 1) begin : g_bad_param
    $error("HAS_CARRIER must be 0 or 1");
  end

  // ==========================================================
  // Register port
  // ==========================================================
  logic [EPT_DATA_W-1:0] next_direction;  // Direction register next value
  logic [EPT_DATA_W-1:0] next_rdata;      // Read data next value

  // Decode writes and reads; unmapped reads return zero
  always_comb begin
    next_direction = port1_direction_out;
    next_rdata     = reg_rdata_out;
    if (reg_wr_in && reg_addr_in == EPT_PORT1_DIRECTION_ADDR) begin
      next_direction = reg_wdata_in;                      // see R2
    end
    if (reg_rd_in) begin
      next_rdata = '0;
      if (reg_addr_in == EPT_PORT1_DIRECTION_ADDR) begin
        next_rdata = port1_direction_out;
      end else if (reg_addr_in == EPT_CARRIER_STATUS_ADDR) begin
        next_rdata[EPT_CARRIER_FLAG_BIT] = carrier_gate_flag_out;
        next_rdata[EPT_CARRIER_BUF_BIT]  = carrier_gate_buffer_in;
      end
    end
  end

  // Register port flops
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      port1_direction_out <= EPT_PORT1_DIRECTION_RST;     // see R1
      reg_rdata_out       <= '0;
    end else begin
      port1_direction_out <= next_direction;
      reg_rdata_out       <= next_rdata;
    end
  end

  // ==========================================================
  // Carrier gate
  // ==========================================================
  ept_carrier_gate u_gate (
    .core_clk_in                    (core_clk_in),
    .reset_in                       (reset_in),
    .count_tick_in                  (count_tick_in),
    .companion_irq_in               (companion_irq_in),
    .carrier_gate_buffer_in         (carrier_gate_buffer_in),
    .synced_companion_interrupt_out (synced_companion_interrupt_out),
    .carrier_gate_flag_out          (carrier_gate_flag_out)
  );

  // ==========================================================
  // Counter state
  // ==========================================================
  logic [EPT_CNT_W-1:0] cnt;          // Timer counter
  ept_phase_t           phase;        // Which compare is live
  logic                 act;          // Output active (before level)
  logic                 mask;         // Swallow next count clock
  logic [EPT_CNT_W-1:0] duty_active;  // Duty compare in use
  logic [EPT_CNT_W-1:0] duty_latch;   // Written, not yet applied
  logic                 duty_pend;    // Latch holds a new value
  logic [1:0]           duty_age;     // Count clocks since write
  logic [EPT_CNT_W-1:0] next_cnt;
  ept_phase_t           next_phase;
  logic                 next_act;
  logic                 next_mask;
  logic                 next_irq;
  logic                 next_pin;
  logic [EPT_CNT_W-1:0] next_duty_active;
  logic [EPT_CNT_W-1:0] next_duty_latch;
  logic                 next_duty_pend;
  logic [1:0]           next_duty_age;
  logic                 duty_ripe;    // Latch old enough to move
  logic                 carrier_ok;   // Carrier mode allowed here

  assign carrier_ok = (HAS_CARRIER == 1);
  assign duty_ripe  = duty_pend && (duty_age >= EPT_DUTY_SETTLE); // see R14

  function automatic logic [EPT_CNT_W-1:0] inc(input logic [EPT_CNT_W-1:0] v);
    inc = v + EPT_CNT_ONE;            // Wraps at the 8-bit limit
  endfunction : inc

  // Next counter, phase and output state
  always_comb begin
    next_cnt         = cnt;
    next_phase       = phase;
    next_act         = act;
    next_mask        = mask;
    next_irq         = match_interrupt_out;
    next_duty_active = duty_active;
    next_duty_latch  = duty_latch;
    next_duty_pend   = duty_pend;
    next_duty_age    = duty_age;
    // Duty write is only latched; age counts count clocks after it
    if (duty_compare_wr_in) begin
      next_duty_latch = duty_compare_in;                  // see R14
      next_duty_pend  = 1'b1;
      next_duty_age   = EPT_AGE_ZERO;
    end else if (duty_pend && count_tick_in && duty_age < EPT_DUTY_SETTLE) begin
      next_duty_age = duty_age + EPT_AGE_ONE;
    end
    if (!count_enable_bit_in) begin
      // Stopped: hold at zero, force everything inactive
      next_cnt   = EPT_CNT_ZERO;                          // see R20
      next_phase = EPT_PH_FIRST;
      next_act   = 1'b0;                                  // see R8
      next_irq   = 1'b0;                                  // see R23
      next_mask  = 1'b1;                                  // see R16
      // No counting, so a waiting value can go straight in
      if (duty_compare_wr_in) begin
        next_duty_active = duty_compare_in;
        next_duty_pend   = 1'b0;
      end else if (duty_pend) begin
        next_duty_active = duty_latch;
        next_duty_pend   = 1'b0;
      end
    end else if (count_tick_in) begin
      next_irq = 1'b0;                // Pulse lasts one count clock
      if (mask) begin
        next_mask = 1'b0;             // First clock after start is lost; see R7
      end else begin
        case (timer_mode_in)
          EPT_MODE_INTERVAL: begin
            // Only the period compare is looked at; see R5
            if (cnt == period_compare_in) begin
              next_cnt = EPT_CNT_ZERO;                    // see R4
              next_irq = 1'b1;
              next_act = !act;                            // see R6
            end else begin
              next_cnt = inc(cnt);
            end
          end
          EPT_MODE_PWM: begin
            if (phase == EPT_PH_FIRST) begin
              if (cnt == period_compare_in) begin
                next_cnt   = EPT_CNT_ZERO;                // see R10
                next_irq   = 1'b1;
                next_act   = 1'b1;
                next_phase = EPT_PH_SECOND;
              end else begin
                next_cnt = inc(cnt);                      // see R12
              end
            end else begin
              next_cnt = inc(cnt);    // Never cleared here; see R11
              if (cnt == duty_active) begin
                next_act   = 1'b0;                        // see R11
                next_phase = EPT_PH_FIRST;
                if (duty_ripe) begin
                  next_duty_active = duty_latch;          // see R14
                  next_duty_pend   = duty_compare_wr_in;  // Same-cycle write stays pending
                end
              end
            end
          end
          EPT_MODE_CARRIER: begin
            if (carrier_ok) begin
              // Low width from period register, high width from duty
              if (phase == EPT_PH_FIRST && cnt == period_compare_in) begin
                next_cnt   = EPT_CNT_ZERO;                // see R17
                next_irq   = 1'b1;
                next_act   = 1'b1;
                next_phase = EPT_PH_SECOND;
              end else if (phase == EPT_PH_SECOND && cnt == duty_active) begin
                next_cnt   = EPT_CNT_ZERO;                // see R17
                next_irq   = 1'b1;
                next_act   = 1'b0;
                next_phase = EPT_PH_FIRST;
                if (duty_ripe) begin
                  next_duty_active = duty_latch;          // see R14
                  next_duty_pend   = duty_compare_wr_in;  // Same-cycle write stays pending
                end
              end else begin
                next_cnt = inc(cnt);
              end
            end
          end
          default: begin
            next_cnt = cnt;           // Prohibited mode: counter frozen
          end
        endcase
      end
    end
    // Pin: idle level unless enabled and active; carrier also needs the gate
    next_pin = idle_level_bit_in;                         // see R21
    if (output_enable_bit_in && act) begin
      if (timer_mode_in != EPT_MODE_CARRIER || carrier_gate_flag_out) begin
        next_pin = !idle_level_bit_in;                    // see R19
      end
    end
  end

  // Counter flops
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt                  <= EPT_CNT_ZERO;
      phase                <= EPT_PH_FIRST;
      act                  <= 1'b0;
      mask                 <= 1'b1;
      match_interrupt_out  <= 1'b0;
      timer_output_pin_out <= 1'b0;
      duty_active          <= EPT_CNT_ZERO;
      duty_latch           <= EPT_CNT_ZERO;
      duty_pend            <= 1'b0;
      duty_age             <= EPT_AGE_ZERO;
    end else begin
      cnt                  <= next_cnt;
      phase                <= next_phase;
      act                  <= next_act;
      mask                 <= next_mask;
      match_interrupt_out  <= next_irq;
      timer_output_pin_out <= next_pin;
      duty_active          <= next_duty_active;
      duty_latch           <= next_duty_latch;
      duty_pend            <= next_duty_pend;
      duty_age             <= next_duty_age;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_live_tick;
    count_enable_bit_in && count_tick_in && !mask;
  endsequence

  sequence s_period_hit;
    s_live_tick ##0 (phase == EPT_PH_FIRST && cnt == period_compare_in);
  endsequence

  AST_DIR_RESET: assert property (@(posedge core_clk_in) // see R1
    reset_in |=> port1_direction_out == EPT_PORT1_DIRECTION_RST)
    else $error("direction not all ones after reset");

  AST_DIR_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R2
    reg_wr_in && reg_addr_in == EPT_PORT1_DIRECTION_ADDR |=>
      port1_direction_out == $past(reg_wdata_in))
    else $error("direction write lost");

  AST_INTERVAL_MATCH: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R4
    s_live_tick ##0 (timer_mode_in == EPT_MODE_INTERVAL && cnt == period_compare_in)
      |=> cnt == EPT_CNT_ZERO && match_interrupt_out)
    else $error("interval match did not clear and interrupt");

  AST_INTERVAL_NO_DUTY: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R5
    s_live_tick ##0 (timer_mode_in == EPT_MODE_INTERVAL && cnt != period_compare_in)
      |=> cnt == inc($past(cnt)) && !match_interrupt_out && act == $past(act))
    else $error("interval mode reacted to something other than period");

  AST_INTERVAL_TOGGLE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R6
    s_live_tick ##0 (timer_mode_in == EPT_MODE_INTERVAL && cnt == period_compare_in)
      |=> act != $past(act))
    else $error("square wave did not toggle");

  AST_STOP: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R8
    !count_enable_bit_in |=> cnt == EPT_CNT_ZERO && !act ##1 !match_interrupt_out)
    else $error("stop did not force inactive");

  AST_START_MASK: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R16
    count_enable_bit_in && count_tick_in && mask |=>
      !mask && cnt == $past(cnt) && !act)
    else $error("first count clock after start not masked");

  AST_PWM_PERIOD: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R10
    s_period_hit ##0 (timer_mode_in == EPT_MODE_PWM) |=>
      cnt == EPT_CNT_ZERO && act && match_interrupt_out && phase == EPT_PH_SECOND)
    else $error("PWM period match wrong");

  AST_PWM_DUTY: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R11
    s_live_tick ##0 (timer_mode_in == EPT_MODE_PWM && phase == EPT_PH_SECOND &&
      cnt == duty_active) |=> !act && phase == EPT_PH_FIRST &&
      !match_interrupt_out && cnt == inc($past(cnt)))
    else $error("PWM duty match wrong");

  AST_DUTY_SETTLE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R14
    !$past(reset_in) && count_enable_bit_in && $past(count_enable_bit_in) &&
      duty_active != $past(duty_active) |-> $past(duty_ripe))
    else $error("duty applied before settling");

  AST_PIN_IDLE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R21
    !output_enable_bit_in |=> timer_output_pin_out == $past(idle_level_bit_in))
    else $error("disabled output not at idle level");

  AST_CARRIER_GATE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R19
    timer_mode_in == EPT_MODE_CARRIER && !carrier_gate_flag_out |=>
      timer_output_pin_out == $past(idle_level_bit_in))
    else $error("carrier leaked through closed gate");

  AST_IRQ_ENABLED: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R23
    match_interrupt_out |-> $past(count_enable_bit_in))
    else $error("interrupt while disabled");

endmodule : ept_timer

`default_nettype wire

// ---- verification/ept_tb.sv ----
/*
  Self-checking bench for ept_timer: register and gate cases, then a table
  of timer modes with stop checks, then PWM duty, idle-level and carrier gate cases.
  Assumes ept_pkg; one count tick on every system clock, every other once slow is set.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ept_pkg::*;
  // ==========================================================
  // Stimulus and observation
  // ==========================================================
  typedef struct {ept_mode_t m; logic [7:0] n, d; int hi, per, nirq;} ept_row_t;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tick = 1'b1, en = 1'b0;
  logic oe = 1'b1, idle = 1'b0, duty_wr = 1'b0, gbuf = 1'b0, cirq = 1'b0, slow = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, per_c = 8'h00, duty_c = 8'h00, rdata, dir;
  ept_mode_t   mode = EPT_MODE_INTERVAL;
  logic        irq, pin, gflag, sirq;
  int          fails = 0, check_count = 0, cyc = 0, hi, per, nirq;
  // Interval duty is set but must be ignored; carrier needs the gate open
  ept_row_t rows[6] = '{'{EPT_MODE_INTERVAL, 8'h03, 8'h01, 4, 8, 2},
    '{EPT_MODE_INTERVAL, 8'h00, 8'h00, 1, 2, 2}, '{EPT_MODE_PWM, 8'h02, 8'h00, 1, 3, 1},
    '{EPT_MODE_PWM, 8'h05, 8'h02, 3, 6, 1}, '{EPT_MODE_PWM, 8'hff, 8'hfe, 255, 256, 1},
    '{EPT_MODE_CARRIER, 8'h02, 8'h01, 2, 5, 2}};
  always #25 clk = ~clk;  // 20 MHz
  // Count clock on every edge, or on every other edge once slow is set
  always @(posedge clk) tick <= slow ? ~tick : 1'b1;
  ept_timer u_dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .count_tick_in(tick),
    .count_enable_bit_in(en), .timer_mode_in(mode), .output_enable_bit_in(oe),
    .idle_level_bit_in(idle), .period_compare_in(per_c), .duty_compare_in(duty_c),
    .duty_compare_wr_in(duty_wr), .carrier_gate_buffer_in(gbuf), .companion_irq_in(cirq),
    .match_interrupt_out(irq), .timer_output_pin_out(pin), .carrier_gate_flag_out(gflag),
    .synced_companion_interrupt_out(sirq), .port1_direction_out(dir));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic reg_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
  endtask : reg_acc
  // One full pin cycle from a rising edge; irq pulses counted alongside
  task automatic measure();
    hi = 0;
    nirq = 0;
    while (pin !== 1'b0) @(negedge clk);
    while (pin !== 1'b1) @(negedge clk);
    while (pin === 1'b1) begin
      hi++;
      nirq += int'(irq === 1'b1);
      @(negedge clk);
    end
    per = hi;
    while (pin === 1'b0) begin
      per++;
      nirq += int'(irq === 1'b1);
      @(negedge clk);
    end
  endtask : measure
  // Hang guard, far above the thousand or so cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("dir_reset", 16'(dir), 16'h00ff);
    reg_acc(1'b1, EPT_PORT1_DIRECTION_ADDR, 8'h9f);  // timer pins to output
    check("dir_write", 16'(dir), 16'h009f);
    reg_acc(1'b0, EPT_PORT1_DIRECTION_ADDR, 8'h00);
    check("dir_read", 16'(rdata), 16'h009f);
    reg_acc(1'b0, 16'h1234, 8'h00);
    check("unmapped_read", 16'(rdata), 16'h0000);
    // Open the carrier gate through the companion interrupt
    @(posedge clk);
    gbuf <= 1'b1;
    cirq <= 1'b1;
    @(posedge clk);
    cirq <= 1'b0;
    repeat (8) @(negedge clk);
    check("gate_flag", 16'(gflag), 16'h0001);
    reg_acc(1'b0, EPT_CARRIER_STATUS_ADDR, 8'h00);
    check("gate_status", 16'(rdata), 16'h0003);
    foreach (rows[i]) begin
      @(posedge clk);
      mode <= rows[i].m;
      per_c <= rows[i].n;  // set before start, duty not above period
      duty_c <= rows[i].d;
      duty_wr <= 1'b1;
      @(posedge clk);
      duty_wr <= 1'b0;
      en <= 1'b1;
      measure();
      check("high_width", 16'(hi), 16'(rows[i].hi));
      check("period", 16'(per), 16'(rows[i].per));
      check("irq_count", 16'(nirq), 16'(rows[i].nirq));
      @(posedge clk);
      en <= 1'b0;
      repeat (3) @(negedge clk);
      check("stop_irq", 16'(irq), 16'h0000);
      check("stop_pin", 16'(pin), 16'h0000);
    end
    // PWM on a count clock of every other edge
    @(posedge clk);
    slow <= 1'b1;
    mode <= EPT_MODE_PWM;
    per_c <= 8'h05;
    duty_c <= 8'h02;
    duty_wr <= 1'b1;
    @(posedge clk);
    duty_wr <= 1'b0;
    en <= 1'b1;
    measure();
    check("slow_high", 16'(hi), 16'd6);
    check("slow_period", 16'(per), 16'd12);
    // Duty rewrite while running: old width first, new one later
    @(posedge clk);
    duty_c <= 8'h01;  // period kept, duty below it
    duty_wr <= 1'b1;
    @(posedge clk);
    duty_wr <= 1'b0;
    measure();
    check("duty_latched", 16'(hi), 16'd6);
    repeat (30) @(negedge clk);
    measure();
    check("duty_applied", 16'(hi), 16'd4);
    check("duty_period", 16'(per), 16'd12);
    // Output disabled: pin idle over a whole period
    @(posedge clk);
    oe <= 1'b0;
    repeat (2) @(negedge clk);
    repeat (12) begin
      @(negedge clk);
      check("oe_off_pin", 16'(pin), 16'h0000);
    end
    // Reset in mid-run, held two edges
    @(posedge clk);
    oe <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("dir_reset2", 16'(dir), 16'h00ff);
    check("gate_reset", 16'(gflag), 16'h0000);
    // Carrier with the gate closed keeps the pin idle
    @(posedge clk);
    en <= 1'b0;
    mode <= EPT_MODE_CARRIER;
    per_c <= 8'h02;  // low width fixed before start
    duty_c <= 8'h01;
    duty_wr <= 1'b1;
    @(posedge clk);
    duty_wr <= 1'b0;
    en <= 1'b1;
    repeat (20) begin
      @(negedge clk);
      check("gate_closed_pin", 16'(pin), 16'h0000);
    end
    @(posedge clk);
    en <= 1'b0;
    idle <= 1'b1;
    repeat (3) @(negedge clk);
    check("idle_pin", 16'(pin), 16'h0001);
    finish_test();
  end
endmodule : tb
`default_nettype wire
